// file: msaf_pkg.sv
// Shared constants and carrier types for the monitor status and alarm flag bank.
// Assumes an APB slave with 32-bit data; registers sit at word addresses.
`default_nettype none

package msaf_pkg;

  // ***************************************************************
  // Register word indices
  // ***************************************************************
  // Printed offsets are not all multiples of four, so each is an index.
  localparam logic [7:0] msaf_idx_status = 8'h6e;
  localparam logic [7:0] msaf_idx_update = 8'h6f;
  localparam logic [7:0] msaf_idx_alarm_primary = 8'h70;
  localparam logic [7:0] msaf_idx_alarm_secondary = 8'h71;
  localparam logic [7:0] msaf_idx_reserved_top = 8'h6d;
  localparam logic [7:0] msaf_idx_thresh_base = 8'h80;
  localparam logic [7:0] msaf_idx_enable_base = 8'h90;
  localparam int msaf_addr_width = 12;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int msaf_st_txd_pin = 7;
  localparam int msaf_st_txd_force = 6;
  localparam int msaf_st_in1 = 5;
  localparam int msaf_st_rate_select_input_pin = 4;
  localparam int msaf_st_rate_select_input_force = 3;
  localparam int msaf_st_txf = 2;
  localparam int msaf_st_los = 1;
  localparam int msaf_st_rdy_n = 0;
  localparam int msaf_upd_range = 0;
  localparam int msaf_sec_fault = 0;
  localparam logic [7:0] msaf_update_reset = 8'h00;
  localparam logic [7:0] msaf_alarm_primary_reset = 8'h10;
  localparam logic [7:0] msaf_alarm_secondary_reset = 8'h00;
  localparam logic [7:0] msaf_update_rdy_mask = 8'hfc;
  localparam logic [15:0] msaf_thresh_hi_reset = 16'hffff;
  localparam logic [15:0] msaf_thresh_lo_reset = 16'h0000;
  localparam logic [15:0] msaf_temp_hi_reset = 16'h7fff;
  localparam logic [15:0] msaf_temp_lo_reset = 16'h8000;
  localparam int msaf_channels = 6;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  // Channel order: 0 temperature, 1 supply, 2..5 monitors one to four.
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [15:0] value;
    logic coarse_range;
  } msaf_conv_type;

  typedef struct packed {
    logic tx_power_high;
    logic tx_power_low;
    logic bias_max;
    logic high_bias;
  } msaf_fast_type;

  typedef struct packed {
    logic tx_disable_pin;
    logic general_input_one;
    logic rate_select_input;
    logic transmit_fault_output;
    logic loss_of_signal_output;
    logic power_on_analog_trip;
  } msaf_pins_type;

endpackage

`default_nettype wire

// file: msaf_flags.sv
// Status, conversion-update and alarm flag registers with an APB slave port.
// Assumes conversion results and pin levels are synchronous to pclk.
//
// What this block does
// - Reserved bytes before status read zero
// - Status bit 7 shows transmit-disable pin
// - Bit 6 soft force ORs transmit-disable
// - Bit 5 shows general input one
// - Bit 4 shows rate-select input pin
// - Bit 3 ORed into rate-select output
// - Bit 2 shows transmit fault output
// - Bit 1 shows loss-of-signal output
// - Bit 0 high while supply below trip
// - Only bits 6 and 3 writable
// - Update bits 7:2 set on conversion
// - Host writes zero to clear ready
// - Update bit 0 reports third-monitor range
// - Primary odd bits are high alarms
// - Primary even bits are low alarms
// - Supply low alarm set below trip
// - Secondary bits 7:4 monitor three, four alarms
// - Secondary bit 0 is fault summary
// - Enable masks held in separate registers
// - Transmit-disable clears fast alarms
// - Temperature compares signed
// - Supply and monitors compare unsigned
//
// The APB interface to the registers was decided locally.
`default_nettype none

module msaf_flags #(
  parameter int chan_count = msaf_pkg::msaf_channels
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msaf_pkg::msaf_addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin levels and analog events
  input wire msaf_pkg::msaf_pins_type pins,
  input wire msaf_pkg::msaf_conv_type conv,
  input wire msaf_pkg::msaf_fast_type fast_raw,
  input wire logic [7:0] warn_flags,
  // Outputs to the module
  output logic tx_disable_state,
  output logic rate_select_output,
  output logic fault_interrupt_summary
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic [7:0] widx;
  logic wr_en;
  logic wr_lane0;
  logic addr_ok;
  assign widx = paddr[9:2];
  assign wr_en = psel && penable && pwrite && wr_lane0;
  assign wr_lane0 = pstrb[0];
  // Zero-wait slave; every access finishes in its first access cycle.
  assign pready = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);

  // ***************************************************************
  // State
  // ***************************************************************
  logic tx_disable_soft_force;
  logic rate_select_soft_force;
  logic [7:0] conversion_update;
  logic [7:0] alarm_flags_primary;
  logic [3:0] alarm_sec_hi;
  logic [7:0] warn_enable;
  logic [7:0] alarm_enable;
  msaf_pkg::msaf_fast_type fast_alarms;
  logic [15:0] thresh_hi [chan_count];
  logic [15:0] thresh_lo [chan_count];
  logic next_tx_disable_soft_force;
  logic next_rate_select_soft_force;
  logic [7:0] next_conversion_update;
  logic [7:0] next_alarm_flags_primary;
  logic [3:0] next_alarm_sec_hi;
  logic [7:0] next_warn_enable;
  logic [7:0] next_alarm_enable;
  msaf_pkg::msaf_fast_type next_fast_alarms;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] pin_status_control;
  logic [7:0] alarm_flags_secondary;
  logic [chan_count-1:0] over_hi;
  logic [chan_count-1:0] under_lo;
  logic prev_txd;
  logic txd_event;

  assign tx_disable_state = pins.tx_disable_pin | tx_disable_soft_force;
  assign rate_select_output = pins.rate_select_input | rate_select_soft_force;
  // A rising transmit-disable level is the event that wipes fast alarms.
  assign txd_event = tx_disable_state && !prev_txd;

  always_comb begin
    pin_status_control = 8'h00;
    pin_status_control[msaf_pkg::msaf_st_txd_pin] = pins.tx_disable_pin;
    pin_status_control[msaf_pkg::msaf_st_txd_force] = tx_disable_soft_force;
    pin_status_control[msaf_pkg::msaf_st_in1] = pins.general_input_one;
    pin_status_control[msaf_pkg::msaf_st_rate_select_input_pin] = pins.rate_select_input;
    pin_status_control[msaf_pkg::msaf_st_rate_select_input_force] = rate_select_soft_force;
    pin_status_control[msaf_pkg::msaf_st_txf] = pins.transmit_fault_output;
    pin_status_control[msaf_pkg::msaf_st_los] = pins.loss_of_signal_output;
    pin_status_control[msaf_pkg::msaf_st_rdy_n] = pins.power_on_analog_trip;
  end

  // ***************************************************************
  // Threshold comparison, one per channel
  // ***************************************************************
  for (genvar c = 0; c < chan_count; c++) begin : g_cmp
    if (c == 0) begin : g_signed
      assign over_hi[c] = $signed(conv.value) > $signed(thresh_hi[c]);
      assign under_lo[c] = $signed(conv.value) < $signed(thresh_lo[c]);
    end else begin : g_unsigned
      assign over_hi[c] = conv.value > thresh_hi[c];
      assign under_lo[c] = conv.value < thresh_lo[c];
    end
  end

  // Thresholds are plain volatile words here; nonvolatile storage lives elsewhere.
  for (genvar c = 0; c < chan_count; c++) begin : g_thr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        thresh_hi[c] <= (c == 0) ? msaf_pkg::msaf_temp_hi_reset : msaf_pkg::msaf_thresh_hi_reset;
        thresh_lo[c] <= (c == 0) ? msaf_pkg::msaf_temp_lo_reset : msaf_pkg::msaf_thresh_lo_reset;
      end else if (psel && penable && pwrite &&
                   widx == msaf_pkg::msaf_idx_thresh_base + 8'(2 * c)) begin
        thresh_hi[c] <= pwdata[15:0];
      end else if (psel && penable && pwrite &&
                   widx == msaf_pkg::msaf_idx_thresh_base + 8'(2 * c + 1)) begin
        thresh_lo[c] <= pwdata[15:0];
      end
    end
  end

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    next_tx_disable_soft_force = tx_disable_soft_force;
    next_rate_select_soft_force = rate_select_soft_force;
    next_conversion_update = conversion_update;
    next_alarm_flags_primary = alarm_flags_primary;
    next_alarm_sec_hi = alarm_sec_hi;
    next_warn_enable = warn_enable;
    next_alarm_enable = alarm_enable;
    next_fast_alarms = fast_alarms;
    // Software writes first, so a same-cycle hardware set below wins.
    if (wr_en) begin
      unique case (widx)
        msaf_pkg::msaf_idx_status: begin
          next_tx_disable_soft_force = pwdata[msaf_pkg::msaf_st_txd_force];
          next_rate_select_soft_force = pwdata[msaf_pkg::msaf_st_rate_select_input_force];
        end
        msaf_pkg::msaf_idx_update: begin
          // Only zeros clear; ones and the range bit are left alone.
          next_conversion_update = conversion_update &
            (pwdata[7:0] | ~msaf_pkg::msaf_update_rdy_mask);
        end
        msaf_pkg::msaf_idx_enable_base: begin
          next_alarm_enable = pwdata[7:0];
        end
        msaf_pkg::msaf_idx_enable_base + 8'h01: begin
          next_warn_enable = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (conv.valid && int'(conv.channel) < chan_count) begin
      next_conversion_update[7 - int'(conv.channel)] = 1'b1;
      unique case (conv.channel)
        3'd0, 3'd1, 3'd2, 3'd3: begin
          next_alarm_flags_primary[7 - 2 * int'(conv.channel)] =
            over_hi[conv.channel];
          next_alarm_flags_primary[6 - 2 * int'(conv.channel)] =
            under_lo[conv.channel];
        end
        3'd4, 3'd5: begin
          next_alarm_sec_hi[3 - 2 * (int'(conv.channel) - 4)] = over_hi[conv.channel];
          next_alarm_sec_hi[2 - 2 * (int'(conv.channel) - 4)] = under_lo[conv.channel];
          if (conv.channel == 3'd4) begin
            next_conversion_update[msaf_pkg::msaf_upd_range] = conv.coarse_range;
          end
        end
        default: begin
        end
      endcase
    end
    if (pins.power_on_analog_trip) begin
      next_alarm_flags_primary[4] = 1'b1;
    end
    // Fast alarms latch their comparators and hold until wiped by a disable event.
    next_fast_alarms = txd_event ? '0 : (fast_alarms | fast_raw);
  end

  always_comb begin
    alarm_flags_secondary = {alarm_sec_hi, 3'b000, 1'b0};
    alarm_flags_secondary[msaf_pkg::msaf_sec_fault] = fault_interrupt_summary;
  end

  // Nonmaskable fast terms sit beside the masked alarm and warning flags.
  assign fault_interrupt_summary =
    |(alarm_flags_primary & alarm_enable) | |(warn_flags & warn_enable) |
    fast_alarms.tx_power_high | fast_alarms.tx_power_low |
    fast_alarms.bias_max | fast_alarms.high_bias;

  // ***************************************************************
  // Read data
  // ***************************************************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable && !pwrite) begin
      if (!addr_ok) begin
        next_pslverr = 1'b1;
      end else if (widx <= msaf_pkg::msaf_idx_reserved_top) begin
        next_prdata = 32'h0000_0000;
      end else if (widx == msaf_pkg::msaf_idx_status) begin
        next_prdata = {24'h00_0000, pin_status_control};
      end else if (widx == msaf_pkg::msaf_idx_update) begin
        next_prdata = {24'h00_0000, conversion_update};
      end else if (widx == msaf_pkg::msaf_idx_alarm_primary) begin
        next_prdata = {24'h00_0000, alarm_flags_primary};
      end else if (widx == msaf_pkg::msaf_idx_alarm_secondary) begin
        next_prdata = {24'h00_0000, alarm_flags_secondary};
      end else if (widx == msaf_pkg::msaf_idx_enable_base) begin
        next_prdata = {24'h00_0000, alarm_enable};
      end else if (widx == msaf_pkg::msaf_idx_enable_base + 8'h01) begin
        next_prdata = {24'h00_0000, warn_enable};
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel && !penable && pwrite && !addr_ok) begin
      next_pslverr = 1'b1;
    end else if (psel && penable) begin
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_disable_soft_force <= 1'b0;
      rate_select_soft_force <= 1'b0;
      conversion_update <= msaf_pkg::msaf_update_reset;
      alarm_flags_primary <= msaf_pkg::msaf_alarm_primary_reset;
      alarm_sec_hi <= 4'h0;
      warn_enable <= 8'h00;
      alarm_enable <= 8'h00;
      fast_alarms <= '0;
      prev_txd <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      tx_disable_soft_force <= next_tx_disable_soft_force;
      rate_select_soft_force <= next_rate_select_soft_force;
      conversion_update <= next_conversion_update;
      alarm_flags_primary <= next_alarm_flags_primary;
      alarm_sec_hi <= next_alarm_sec_hi;
      warn_enable <= next_warn_enable;
      alarm_enable <= next_alarm_enable;
      fast_alarms <= next_fast_alarms;
      prev_txd <= tx_disable_state;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

`default_nettype wire

// file: msaf_flags_checker.sv
// Concurrent checks on the flag bank ports: read capture, pin mirrors, alarm summary.
// Assumes one pclk domain and alarm or warning enables left at their reset value.
`default_nettype none

module msaf_flags_checker #(
  parameter int chan_count = msaf_pkg::msaf_channels
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msaf_pkg::msaf_addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins, events and outputs
  input wire msaf_pkg::msaf_pins_type pins,
  input wire msaf_pkg::msaf_conv_type conv,
  input wire msaf_pkg::msaf_fast_type fast_raw,
  input wire logic [7:0] warn_flags,
  input wire logic tx_disable_state,
  input wire logic rate_select_output,
  input wire logic fault_interrupt_summary
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // **********
  // Bus phases
  // **********
  // Read data is captured in the setup cycle, so checks compare against values one edge back.
  sequence s_rd(logic [7:0] idx);
    psel && !penable && !pwrite && paddr == {2'b00, idx, 2'b00};
  endsequence
  sequence s_wr(logic [7:0] idx);
    psel && penable && pready && pwrite && pstrb[0] && paddr == {2'b00, idx, 2'b00};
  endsequence
  a_status_pins:
    assert property (s_rd(8'h6e) |=> (prdata[7:0] & 8'hb7) == {$past(pins.tx_disable_pin),
      1'b0, $past(pins.general_input_one), $past(pins.rate_select_input), 1'b0,
      $past(pins.transmit_fault_output), $past(pins.loss_of_signal_output),
      $past(pins.power_on_analog_trip)}) else $error("status mirror wrong");
  a_status_force:
    assert property (s_rd(8'h6e) ##0 !pins.tx_disable_pin |=> prdata[6] == $past(tx_disable_state))
      else $error("transmit-disable force bit wrong");
  a_rate_select_input_force:
    assert property (s_rd(8'h6e) ##0 !pins.rate_select_input
      |=> prdata[3] == $past(rate_select_output)) else $error("rate force bit wrong");
  a_force_write:
    assert property (s_wr(8'h6e) ##0 pwdata[6] |=> tx_disable_state) else $error("force lost");
  a_txd_follow:
    assert property (pins.tx_disable_pin |-> tx_disable_state) else $error("pin not ORed");
  a_rate_select_input_follow:
    assert property (pins.rate_select_input |-> rate_select_output) else $error("rate not ORed");
  a_reserved_zero:
    assert property (psel && !penable && !pwrite && paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00
      && paddr[9:2] <= 8'h6d |=> prdata[7:0] == 8'h00) else $error("reserved byte not zero");
  a_fast_set:
    assert property (|fast_raw && !tx_disable_state |=> fault_interrupt_summary)
      else $error("fast alarm missing from summary");
  a_fast_clear:
    assert property ($rose(tx_disable_state) |=> !fault_interrupt_summary)
      else $error("disable event kept fast alarm");
  a_supply_trip:
    assert property (s_rd(8'h70) ##0 $past(pins.power_on_analog_trip) |=> prdata[4])
      else $error("supply low not forced");
endmodule

bind msaf_flags msaf_flags_checker #(.chan_count(chan_count)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .conv(conv), .fast_raw(fast_raw), .warn_flags(warn_flags),
  .tx_disable_state(tx_disable_state), .rate_select_output(rate_select_output),
  .fault_interrupt_summary(fault_interrupt_summary));

`default_nettype wire

// file: msaf_host_model.sv
// Host model: APB master that reaches the flag bank one byte per word.
// Assumes the bench calls xfer from one process at a time.
`default_nettype none

module msaf_host_model (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [msaf_pkg::msaf_addr_width-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Raised when a slave never answers
  output logic hung
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    hung = 1'b0;
  end
  // **********
  // Transfer
  // **********
  // Released write data is inverted so the slave cannot lean on a stale value.
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [15:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 0; n < 64 && pready !== 1'b1; n++) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    hung <= (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule

`default_nettype wire

// file: tb_monitor_status_alarm_flags.sv
// Bench for the flag bank: register reads and writes, conversions, pins, fast alarms.
// Assumes the host model for bus traffic and the checker bound to the design.
`default_nettype none

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_monitor_status_alarm_flags;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_hung, err;
  logic tx_dis, rate_select_input_out, fault;
  logic [msaf_pkg::msaf_addr_width-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] warn_flags, rd;
  msaf_pkg::msaf_pins_type pins;
  msaf_pkg::msaf_conv_type conv;
  msaf_pkg::msaf_fast_type fast_raw;
  int failures, compares;
  logic [7:0] st_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h80};
  logic [2:0] t_ch [8] = '{3'd0, 3'd0, 3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5};
  logic [7:0] t_idx [8] = '{8'h80, 8'h81, 8'h80, 8'h82, 8'h84, 8'h87, 8'h88, 8'h8b};
  logic [15:0] t_thr [8] = '{16'h0100, 16'hff00, 16'h0100, 16'hffff, 16'h8000, 16'h0010,
                             16'h1000, 16'h0010};
  logic [15:0] t_val [8] = '{16'hfe00, 16'hfe00, 16'h0200, 16'h0000, 16'h8001, 16'h000f,
                             16'h2000, 16'h0000};
  logic [7:0] t_pri [8] = '{8'h10, 8'h50, 8'h90, 8'h80, 8'h88, 8'h89, 8'h89, 8'h89};
  logic [7:0] t_sec [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h90};
  logic [7:0] t_upd [8] = '{8'h80, 8'h80, 8'h80, 8'hc0, 8'he0, 8'hf0, 8'hf9, 8'hfd};

  msaf_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hung(host_hung));
  msaf_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .conv(conv), .fast_raw(fast_raw),
    .warn_flags(warn_flags), .tx_disable_state(tx_dis), .rate_select_output(rate_select_input_out),
    .fault_interrupt_summary(fault));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // **********
  // Tasks
  // **********
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic e;
    host.xfer(idx, 1'b0, 16'h0000, d, e);
    `CHK(d, exp)
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    logic [7:0] d;
    logic e;
    host.xfer(idx, 1'b1, v, d, e);
  endtask
  task automatic convert(input logic [2:0] ch, input logic [15:0] v, input logic coarse);
    @(posedge pclk);
    conv <= {1'b1, ch, v, coarse};
    @(posedge pclk);
    conv <= '0;
  endtask
  always @(posedge host_hung) begin
    failures++;
    end_sim();
  end
  // **********
  // Scenarios
  // **********
  initial begin
    presetn = 1'b0;
    pins = '0;
    conv = '0;
    fast_raw = '0;
    warn_flags = 8'hff;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h6e, 8'h00);
    rd_chk(8'h6f, 8'h00);
    rd_chk(8'h70, 8'h10);
    rd_chk(8'h71, 8'h00);
    wr(8'h6d, 16'h00ff);
    rd_chk(8'h6d, 8'h00);
    rd_chk(8'h00, 8'h00);
    host.xfer(8'ha0, 1'b0, 16'h0000, rd, err);
    `CHK(err, 1'b1)
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      pins <= 6'b000001 << i;
      rd_chk(8'h6e, st_exp[i]);
    end
    @(posedge pclk);
    pins <= '0;
    wr(8'h6e, 16'h00ff);
    rd_chk(8'h6e, 8'h48);
    @(negedge pclk);
    `CHK({tx_dis, rate_select_input_out}, 2'b11)
    wr(8'h70, 16'h00ff);
    rd_chk(8'h70, 8'h10);
    wr(8'h6e, 16'h0000);
    @(negedge pclk);
    `CHK({tx_dis, rate_select_input_out}, 2'b00)
    $display("test status_bits done");
    for (int k = 0; k < 8; k++) begin
      wr(t_idx[k], t_thr[k]);
      convert(t_ch[k], t_val[k], t_ch[k] == 3'd4);
      rd_chk(8'h70, t_pri[k]);
      rd_chk(8'h71, t_sec[k]);
      rd_chk(8'h6f, t_upd[k]);
    end
    `CHK(fault, 1'b0)
    $display("test conversions done");
    wr(8'h6f, 16'h0003);
    rd_chk(8'h6f, 8'h01);
    convert(3'd3, 16'h0000, 1'b0);
    convert(3'd4, 16'h2000, 1'b0);
    wr(8'h6f, 16'h00fc);
    rd_chk(8'h6f, 8'h18);
    @(posedge pclk);
    pins <= 6'b100000;
    rd_chk(8'h71, 8'h90);
    @(posedge pclk);
    pins <= 6'b000001;
    rd_chk(8'h70, 8'h99);
    rd_chk(8'h6e, 8'h01);
    @(posedge pclk);
    pins <= '0;
    convert(3'd1, 16'h0100, 1'b0);
    rd_chk(8'h70, 8'h89);
    wr(8'h91, 16'h0001);
    rd_chk(8'h71, 8'h91);
    wr(8'h91, 16'h0000);
    wr(8'h90, 16'h0008);
    rd_chk(8'h71, 8'h91);
    wr(8'h90, 16'h0000);
    rd_chk(8'h71, 8'h90);
    $display("test ready_and_trip done");
    for (int b = 0; b < 4; b++) begin
      @(posedge pclk);
      fast_raw <= 4'b0001 << b;
      @(posedge pclk);
      fast_raw <= '0;
      rd_chk(8'h71, 8'h91);
      @(posedge pclk);
      pins <= 6'b100000;
      @(posedge pclk);
      pins <= '0;
      @(negedge pclk);
      `CHK(fault, 1'b0)
    end
    $display("test fast_alarms done");
    end_sim();
  end
endmodule

`default_nettype wire
